// *** inc/drive_status_pkg.sv ***
// constants shared by the drive status and relative preset block
package drive_status_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_COMMANDED = 8'h03; // commanded position
  localparam logic [7:0] IDX_FUNC_GEN = 8'h08; // function generator position
  localparam logic [7:0] IDX_STATUS = 8'h23; // error and status word
  localparam logic [7:0] IDX_PRESET_SEL = 8'h2B; // preset activation
  localparam logic [7:0] IDX_PRESET_BASE = 8'h31; // first preset word
  localparam logic [7:0] IDX_FILT_LO = 8'h6A; // filters 106..111
  localparam logic [7:0] IDX_FILT_HI = 8'h7F; // filters 127..128
  localparam logic [7:0] IDX_SUPPLY = 8'h97; // measured supply
  localparam logic [7:0] IDX_SUPPLY_MIN = 8'h98; // minimum supply
  localparam logic [7:0] IDX_TARGET = 8'hC8; // target position
  localparam logic [7:0] IDX_LIMIT_MIN = 8'hC9; // lower position limit
  localparam logic [7:0] IDX_LIMIT_MAX = 8'hCA; // upper position limit
  localparam logic [7:0] IDX_IRQ_MASK = 8'hCB; // interrupt mask
  localparam logic [7:0] IDX_CONFIG = 8'hCC; // drive configuration
  // geometry
  localparam int ADDR_W = 10; // byte address width
  localparam int NUM_PRESETS = 8; // general purpose position presets
  localparam int NUM_FILTERS = 8; // current loop filter words
  localparam int FILT_LO_COUNT = 6; // filters in the low group
  // status word field positions
  localparam int BIT_REL_CMD = 9; // relative to commanded select
  localparam int BIT_REL_FNC = 10; // relative to function select
  localparam int BIT_OVC = 11; // winding overcurrent flag
  localparam int BIT_UNDERVOLTAGE_ERROR_FLAG = 12; // undervoltage error flag
  localparam int BIT_UV_WARN = 13; // undervoltage warning flag
  localparam int BIT_LIM_SUSP = 14; // position limit suspend
  localparam int BIT_UV_REPORT = 0; // config: report undervoltage error
  // warning threshold is min * WARN_NUM / WARN_DEN, i.e. 1.25
  localparam int WARN_NUM = 5;
  localparam int WARN_DEN = 4;
  // reset values
  localparam logic [31:0] LIMIT_MIN_RESET = 32'h8000_0000;
  localparam logic [31:0] LIMIT_MAX_RESET = 32'h7FFF_FFFF;
  localparam logic [15:0] SUPPLY_MIN_RESET = 16'h0000;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0001;
  // current filter defaults, restored on overcurrent
  localparam logic [NUM_FILTERS-1:0][31:0] FILTER_DEFAULTS = {
    32'h0000_0008, 32'h0000_0007, 32'h0000_0006, 32'h0000_0005,
    32'h0000_0004, 32'h0000_0003, 32'h0000_0002, 32'h0000_0001};
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** design/preset_target_calc.sv ***
// target position produced when a preset is activated
`timescale 1ns/100ps
module preset_target_calc
(
  input wire logic [31:0] preset_value,
  input wire logic rel_cmd,
  input wire logic rel_fnc,
  input wire logic [31:0] commanded_position,
  input wire logic [31:0] function_gen_position,
  output logic [31:0] target_value
);
  // pick the offset; commanded wins when both selects are set
  always_comb
  begin
    if (rel_cmd)
    begin
      target_value = preset_value + commanded_position;
    end
    else if (rel_fnc)
    begin
      target_value = preset_value + function_gen_position;
    end
    else
    begin
      target_value = preset_value;
    end
  end
endmodule

// *** design/supply_monitor.sv ***
// compares the measured supply with the error and warning thresholds
`timescale 1ns/100ps
module supply_monitor
#(
  parameter int VOLT_W = 16
)
(
  input wire logic [VOLT_W-1:0] supply_voltage,
  input wire logic [VOLT_W-1:0] supply_min,
  output logic below_min,
  output logic below_warn
);
  // widened so min * 5 never wraps
  logic [VOLT_W+2:0] supply_scaled;
  logic [VOLT_W+2:0] min_scaled;
  // warning compares supply*4 against min*5, avoiding a divider
  always_comb
  begin
    supply_scaled = {3'h0, supply_voltage} *
      (VOLT_W+3)'(drive_status_pkg::WARN_DEN);
    min_scaled = {3'h0, supply_min} *
      (VOLT_W+3)'(drive_status_pkg::WARN_NUM);
    below_min = supply_voltage < supply_min;
    below_warn = supply_scaled < min_scaled;
  end
endmodule

// *** design/drive_status_relpos.sv ***
// drive status word, relative preset targeting and axi4-lite registers
// Function
// - both selects clear: preset copied to target
// - bit 9: preset plus commanded position
// - bit 10 with bit 9 clear: preset plus function position
// - all eight presets, every activation source
// - bit 11 set on winding overcurrent
// - overcurrent restores current filter defaults
// - bit 12 on undervoltage if reporting enabled
// - bit 13 warns below 1.25 times minimum
// - bit 14 suspends position limit enforcement
// - bit 14 set by zero search or host
// - bit 14 clears when position back inside
`timescale 1ns/100ps
module drive_status_relpos
(
  input wire logic clk,
  input wire logic reset_n,
  // axi4-lite slave
  input wire logic [drive_status_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [drive_status_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // motion inputs
  input wire logic [31:0] commanded_position,
  input wire logic [31:0] function_gen_position,
  input wire logic [31:0] actual_position,
  input wire logic [15:0] supply_voltage,
  input wire logic winding_overcurrent_detect,
  input wire logic zero_search_active,
  // preset activation requests, index 0..7 for presets 1..8
  input wire logic quick_bus_command_act,
  input wire logic [2:0] quick_bus_command_idx,
  input wire logic bi_position_act,
  input wire logic [2:0] bi_position_idx,
  input wire logic manual_resync_act,
  input wire logic [2:0] manual_resync_idx,
  // outputs
  output logic [31:0] target_position,
  output logic [drive_status_pkg::NUM_FILTERS-1:0][31:0] filter_settings,
  output logic position_limit_enforce,
  output logic position_limit_violation,
  output logic irq
);
  localparam int NP = drive_status_pkg::NUM_PRESETS;
  localparam int NF = drive_status_pkg::NUM_FILTERS;

  // whole module state
  typedef struct packed {
    logic aw_have; // write address held
    logic [7:0] aw_idx; // held write index
    logic w_have; // write data held
    logic [31:0] wdata; // held write data
    logic [3:0] wstrb; // held byte strobes
    logic bvalid; // write response pending
    logic [1:0] bresp; // write response code
    logic rvalid; // read data pending
    logic [31:0] rdata; // read data
    logic [1:0] rresp; // read response code
    logic rel_cmd; // relative to commanded select
    logic rel_fnc; // relative to function select
    logic ovc; // winding overcurrent flag
    logic undervoltage_error_flag; // undervoltage error flag
    logic uv_warn; // undervoltage warning flag
    logic lim_susp; // position limit suspend
    logic [31:0] irq_mask; // mask, status word layout
    logic [31:0] config_word; // drive configuration
    logic [3:0] preset_sel; // last value written to preset select
    logic [15:0] supply_min; // minimum supply
    logic [31:0] limit_min; // lower position limit
    logic [31:0] limit_max; // upper position limit
    logic [31:0] target; // target position
    logic [NP-1:0][31:0] preset; // position presets
    logic [NF-1:0][31:0] filter; // current loop filters
  } state_t;

  state_t q_r;
  state_t q_nxt;

  logic [31:0] status_word; // assembled status word
  logic act_fire; // some preset activation this cycle
  logic [2:0] act_idx; // preset being activated
  logic [31:0] calc_target; // computed target for act_idx
  logic below_min; // supply below minimum
  logic below_warn; // supply below warning threshold
  logic pos_inside; // actual position within limits
  logic do_write; // bus write executes this cycle
  logic wr_sel_hit; // write to preset select with valid value
  logic [31:0] wr_be; // byte enable mask of held write

  // merge byte lanes of a write into an old value
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
    input logic [31:0] new_v, input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // filter index for a register index, or NF when none
  function automatic int filter_slot(input logic [7:0] idx);
    int slot;
    slot = NF;
    for (int f = 0; f < NF; f++)
    begin
      if (f < drive_status_pkg::FILT_LO_COUNT)
      begin
        if (idx == drive_status_pkg::IDX_FILT_LO + 8'(f))
        begin
          slot = f;
        end
      end
      else if (idx == drive_status_pkg::IDX_FILT_HI +
        8'(f - drive_status_pkg::FILT_LO_COUNT))
      begin
        slot = f;
      end
    end
    return slot;
  endfunction

  // preset slot for a register index, or NP when none
  function automatic int preset_slot(input logic [7:0] idx);
    int slot;
    slot = NP;
    for (int p = 0; p < NP; p++)
    begin
      if (idx == drive_status_pkg::IDX_PRESET_BASE + 8'(2 * p))
      begin
        slot = p;
      end
    end
    return slot;
  endfunction

  // fixed registers that exist in the map
  function automatic logic fixed_hit(input logic [7:0] idx);
    return idx == drive_status_pkg::IDX_COMMANDED ||
      idx == drive_status_pkg::IDX_FUNC_GEN ||
      idx == drive_status_pkg::IDX_STATUS ||
      idx == drive_status_pkg::IDX_PRESET_SEL ||
      idx == drive_status_pkg::IDX_SUPPLY ||
      idx == drive_status_pkg::IDX_SUPPLY_MIN ||
      idx == drive_status_pkg::IDX_TARGET ||
      idx == drive_status_pkg::IDX_LIMIT_MIN ||
      idx == drive_status_pkg::IDX_LIMIT_MAX ||
      idx == drive_status_pkg::IDX_IRQ_MASK ||
      idx == drive_status_pkg::IDX_CONFIG;
  endfunction

  // status word; bits 0..8 belong elsewhere and read zero here
  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[drive_status_pkg::BIT_REL_CMD] = q_r.rel_cmd;
    status_word[drive_status_pkg::BIT_REL_FNC] = q_r.rel_fnc;
    status_word[drive_status_pkg::BIT_OVC] = q_r.ovc;
    status_word[drive_status_pkg::BIT_UNDERVOLTAGE_ERROR_FLAG] = q_r.undervoltage_error_flag;
    status_word[drive_status_pkg::BIT_UV_WARN] = q_r.uv_warn;
    status_word[drive_status_pkg::BIT_LIM_SUSP] = q_r.lim_susp;
  end

  // preset activation: register write first, then the external sources
  always_comb
  begin
    wr_sel_hit = do_write && q_r.aw_idx == drive_status_pkg::IDX_PRESET_SEL
      && q_r.wstrb[0] && q_r.wdata[3:0] >= 4'h1
      && q_r.wdata[3:0] <= 4'h8;
    act_fire = 1'b1;
    act_idx = 3'h0;
    if (wr_sel_hit)
    begin
      act_idx = 3'(q_r.wdata[3:0] - 4'h1);
    end
    else if (quick_bus_command_act)
    begin
      act_idx = quick_bus_command_idx;
    end
    else if (bi_position_act)
    begin
      act_idx = bi_position_idx;
    end
    else if (manual_resync_act)
    begin
      act_idx = manual_resync_idx;
    end
    else
    begin
      act_fire = 1'b0;
    end
  end

  preset_target_calc u_calc (
    .preset_value(q_r.preset[act_idx]),
    .rel_cmd(q_r.rel_cmd),
    .rel_fnc(q_r.rel_fnc),
    .commanded_position(commanded_position),
    .function_gen_position(function_gen_position),
    .target_value(calc_target)
  );

  supply_monitor #(.VOLT_W(16)) u_supply (
    .supply_voltage(supply_voltage),
    .supply_min(q_r.supply_min),
    .below_min(below_min),
    .below_warn(below_warn)
  );

  // signed limit window check
  assign pos_inside = $signed(actual_position) >= $signed(q_r.limit_min) &&
    $signed(actual_position) <= $signed(q_r.limit_max);
  assign do_write = q_r.aw_have && q_r.w_have && !q_r.bvalid;
  assign wr_be = {{8{q_r.wstrb[3]}}, {8{q_r.wstrb[2]}},
    {8{q_r.wstrb[1]}}, {8{q_r.wstrb[0]}}};

  // next state: bus channels, register writes, then hardware events
  always_comb
  begin
    logic [7:0] ridx;
    logic [31:0] wmask;
    logic [31:0] mrg; // merged write word; a call result cannot be indexed
    int ps;
    int fs;
    ridx = s_axi_araddr[9:2];
    wmask = 32'h0000_0000;
    mrg = 32'h0000_0000;
    ps = NP;
    fs = NF;
    q_nxt = q_r;
    // response channels drop after their handshake
    if (q_r.bvalid && s_axi_bready)
    begin
      q_nxt.bvalid = 1'b0;
    end
    if (q_r.rvalid && s_axi_rready)
    begin
      q_nxt.rvalid = 1'b0;
    end
    // address and data are taken independently
    if (s_axi_awvalid && !q_r.aw_have)
    begin
      q_nxt.aw_have = 1'b1;
      q_nxt.aw_idx = s_axi_awaddr[9:2];
    end
    if (s_axi_wvalid && !q_r.w_have)
    begin
      q_nxt.w_have = 1'b1;
      q_nxt.wdata = s_axi_wdata;
      q_nxt.wstrb = s_axi_wstrb;
    end
    // read: answer captured at the edge that takes the address, valid one cycle later
    if (s_axi_arvalid && !q_r.rvalid)
    begin
      ps = preset_slot(ridx);
      fs = filter_slot(ridx);
      q_nxt.rvalid = 1'b1;
      q_nxt.rresp = drive_status_pkg::RESP_OKAY;
      q_nxt.rdata = 32'h0000_0000;
      if (ps < NP)
      begin
        q_nxt.rdata = q_r.preset[ps];
      end
      else if (fs < NF)
      begin
        q_nxt.rdata = q_r.filter[fs];
      end
      else
      begin
        unique case (ridx)
          drive_status_pkg::IDX_COMMANDED: q_nxt.rdata = commanded_position;
          drive_status_pkg::IDX_FUNC_GEN: q_nxt.rdata = function_gen_position;
          drive_status_pkg::IDX_STATUS: q_nxt.rdata = status_word;
          drive_status_pkg::IDX_PRESET_SEL:
            q_nxt.rdata = {28'h0, q_r.preset_sel};
          drive_status_pkg::IDX_SUPPLY: q_nxt.rdata = {16'h0, supply_voltage};
          drive_status_pkg::IDX_SUPPLY_MIN:
            q_nxt.rdata = {16'h0, q_r.supply_min};
          drive_status_pkg::IDX_TARGET: q_nxt.rdata = q_r.target;
          drive_status_pkg::IDX_LIMIT_MIN: q_nxt.rdata = q_r.limit_min;
          drive_status_pkg::IDX_LIMIT_MAX: q_nxt.rdata = q_r.limit_max;
          drive_status_pkg::IDX_IRQ_MASK: q_nxt.rdata = q_r.irq_mask;
          drive_status_pkg::IDX_CONFIG: q_nxt.rdata = q_r.config_word;
          default: q_nxt.rresp = drive_status_pkg::RESP_SLVERR; // unmapped
        endcase
      end
    end
    // write executes once both halves are held
    if (do_write)
    begin
      ps = preset_slot(q_r.aw_idx);
      fs = filter_slot(q_r.aw_idx);
      q_nxt.aw_have = 1'b0;
      q_nxt.w_have = 1'b0;
      q_nxt.bvalid = 1'b1;
      q_nxt.bresp = drive_status_pkg::RESP_OKAY;
      if (ps < NP)
      begin
        q_nxt.preset[ps] = merge_bytes(q_r.preset[ps], q_r.wdata, q_r.wstrb);
      end
      else if (fs < NF)
      begin
        q_nxt.filter[fs] = merge_bytes(q_r.filter[fs], q_r.wdata, q_r.wstrb);
      end
      else if (!fixed_hit(q_r.aw_idx))
      begin
        q_nxt.bresp = drive_status_pkg::RESP_SLVERR;
      end
      wmask = q_r.wdata & wr_be;
      unique case (q_r.aw_idx)
        drive_status_pkg::IDX_STATUS:
        begin
          // selects are plain bits, flags are write-one-to-clear, bit 14 is write-one-to-set
          mrg = merge_bytes(status_word, q_r.wdata, q_r.wstrb);
          q_nxt.rel_cmd = mrg[drive_status_pkg::BIT_REL_CMD];
          q_nxt.rel_fnc = mrg[drive_status_pkg::BIT_REL_FNC];
          q_nxt.ovc = q_r.ovc & ~wmask[drive_status_pkg::BIT_OVC];
          q_nxt.undervoltage_error_flag = q_r.undervoltage_error_flag & ~wmask[drive_status_pkg::BIT_UNDERVOLTAGE_ERROR_FLAG];
          q_nxt.uv_warn = q_r.uv_warn & ~wmask[drive_status_pkg::BIT_UV_WARN];
          q_nxt.lim_susp = q_r.lim_susp |
            wmask[drive_status_pkg::BIT_LIM_SUSP];
        end
        drive_status_pkg::IDX_PRESET_SEL: q_nxt.preset_sel = q_r.wdata[3:0];
        drive_status_pkg::IDX_SUPPLY_MIN:
        begin
          // only the low half exists; upper lanes are dropped
          mrg = merge_bytes({16'h0, q_r.supply_min}, q_r.wdata, q_r.wstrb);
          q_nxt.supply_min = mrg[15:0];
        end
        drive_status_pkg::IDX_TARGET: q_nxt.target =
          merge_bytes(q_r.target, q_r.wdata, q_r.wstrb);
        drive_status_pkg::IDX_LIMIT_MIN: q_nxt.limit_min =
          merge_bytes(q_r.limit_min, q_r.wdata, q_r.wstrb);
        drive_status_pkg::IDX_LIMIT_MAX: q_nxt.limit_max =
          merge_bytes(q_r.limit_max, q_r.wdata, q_r.wstrb);
        drive_status_pkg::IDX_IRQ_MASK: q_nxt.irq_mask =
          merge_bytes(q_r.irq_mask, q_r.wdata, q_r.wstrb);
        drive_status_pkg::IDX_CONFIG: q_nxt.config_word =
          merge_bytes(q_r.config_word, q_r.wdata, q_r.wstrb);
        default: q_nxt.bresp = q_nxt.bresp;
      endcase
    end
    // activation overrides a same-cycle target write
    if (act_fire)
    begin
      q_nxt.target = calc_target;
    end
    // hardware sets come last so they beat any clear
    if (winding_overcurrent_detect)
    begin
      q_nxt.ovc = 1'b1;
      q_nxt.filter = drive_status_pkg::FILTER_DEFAULTS;
    end
    if (below_min && q_r.config_word[drive_status_pkg::BIT_UV_REPORT])
    begin
      q_nxt.undervoltage_error_flag = 1'b1;
    end
    if (below_warn)
    begin
      q_nxt.uv_warn = 1'b1;
    end
    // auto clear when back inside, but a set in the same cycle wins
    if (pos_inside)
    begin
      q_nxt.lim_susp = 1'b0;
    end
    if (zero_search_active || (do_write &&
      q_r.aw_idx == drive_status_pkg::IDX_STATUS &&
      wmask[drive_status_pkg::BIT_LIM_SUSP]))
    begin
      q_nxt.lim_susp = 1'b1;
    end
  end

  // state register with synchronous reset
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      q_r <= '0;
      q_r.config_word <= drive_status_pkg::CONFIG_RESET;
      q_r.supply_min <= drive_status_pkg::SUPPLY_MIN_RESET;
      q_r.limit_min <= drive_status_pkg::LIMIT_MIN_RESET;
      q_r.limit_max <= drive_status_pkg::LIMIT_MAX_RESET;
      q_r.filter <= drive_status_pkg::FILTER_DEFAULTS;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

  // outputs
  assign s_axi_awready = !q_r.aw_have;
  assign s_axi_wready = !q_r.w_have;
  assign s_axi_bvalid = q_r.bvalid;
  assign s_axi_bresp = q_r.bresp;
  assign s_axi_arready = !q_r.rvalid;
  assign s_axi_rvalid = q_r.rvalid;
  assign s_axi_rdata = q_r.rdata;
  assign s_axi_rresp = q_r.rresp;
  assign target_position = q_r.target;
  assign filter_settings = q_r.filter;
  assign position_limit_enforce = !q_r.lim_susp;
  assign position_limit_violation = !q_r.lim_susp && !pos_inside;
  assign irq = |(status_word & q_r.irq_mask);

  a_abs_copy: assert property (@(posedge clk) disable iff (!reset_n)
    act_fire && !q_r.rel_cmd && !q_r.rel_fnc |=>
      q_r.target == $past(q_r.preset[act_idx]))
    else $error("absolute preset copy wrong");
  a_rel_commanded: assert property (@(posedge clk) disable iff (!reset_n)
    act_fire && q_r.rel_cmd |=> q_r.target ==
      $past(q_r.preset[act_idx]) + $past(commanded_position))
    else $error("commanded relative target wrong");
  a_rel_function: assert property (@(posedge clk) disable iff (!reset_n)
    act_fire && q_r.rel_fnc && !q_r.rel_cmd |=> q_r.target ==
      $past(q_r.preset[act_idx]) + $past(function_gen_position))
    else $error("function relative target wrong");
  a_ovc_flag_filter: assert property (@(posedge clk)
    disable iff (!reset_n) winding_overcurrent_detect |=> q_r.ovc &&
      q_r.filter == drive_status_pkg::FILTER_DEFAULTS)
    else $error("overcurrent flag or filter restore missing");
  a_undervoltage_error_flag_gate: assert property (@(posedge clk) disable iff (!reset_n)
    !$past(q_r.undervoltage_error_flag) && q_r.undervoltage_error_flag |->
      $past(below_min) && $past(q_r.config_word[0]))
    else $error("undervoltage error without cause");
  a_uv_warn_set: assert property (@(posedge clk) disable iff (!reset_n)
    below_warn |=> q_r.uv_warn)
    else $error("undervoltage warning not set");
  a_limit_enforce: assert property (@(posedge clk) disable iff (!reset_n)
    q_r.lim_susp |-> !position_limit_enforce && !position_limit_violation)
    else $error("limits enforced while suspended");
  a_susp_zero: assert property (@(posedge clk) disable iff (!reset_n)
    zero_search_active |=> q_r.lim_susp [*1])
    else $error("zero search did not suspend limits");
  a_susp_clear: assert property (@(posedge clk) disable iff (!reset_n)
    q_r.lim_susp && pos_inside && !zero_search_active && !do_write
      |=> !q_r.lim_susp)
    else $error("limit suspend not cleared inside range");
endmodule

// *** tb/drive_status_relpos_tb_top.sv ***
// self-checking bench for the drive status and relative preset block
`timescale 1ns/100ps
module drive_status_relpos_tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [9:0] awaddr = 10'h000, araddr = 10'h000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, cmd_p = 32'h0, fnc_p = 32'h0, act_p = 32'h0;
  logic [15:0] sup = 16'h03E8; // healthy supply
  logic oc = 1'b0, zs = 1'b0;
  logic [2:0] act_v = 3'h0, aidx = 3'h0; // quick, bi-position, resync
  logic awready, wready, bvalid, arready, rvalid, enf, viol, irq;
  logic [1:0] bresp, rresp, rs, bs;
  logic [31:0] rdata, tgt, rd, exp_t, c, f;
  logic [7:0][31:0] filt;
  logic [31:0] pv [8]; // model of the preset words
  logic [2:0] i;
  int n_errors = 0, checks = 0, cyc = 0;

  // 250 MHz clock
  always #2 clk = ~clk;

  drive_status_relpos u_drive_status_relpos (.clk(clk), .reset_n(reset_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .commanded_position(cmd_p), .function_gen_position(fnc_p),
    .actual_position(act_p), .supply_voltage(sup),
    .winding_overcurrent_detect(oc), .zero_search_active(zs),
    .quick_bus_command_act(act_v[0]), .quick_bus_command_idx(aidx),
    .bi_position_act(act_v[1]), .bi_position_idx(aidx),
    .manual_resync_act(act_v[2]), .manual_resync_idx(aidx),
    .target_position(tgt), .filter_settings(filt),
    .position_limit_enforce(enf), .position_limit_violation(viol), .irq(irq));

  task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
    checks++;
    if (seen !== expv)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask

  // one axi write; each channel released once its ready is sampled
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    @(posedge clk);
    awaddr <= {idx, 2'h0};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bs = bresp;
    bready <= 1'b0;
  endtask

  // one axi read; data taken at the edge where rvalid is seen
  task automatic rdr(input logic [7:0] idx);
    @(posedge clk);
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [31:0] expv);
    rdr(idx);
    chk(rd, expv);
  endtask

  // activate preset n from source s; 0 is the register write
  task automatic fire(input int s, input logic [2:0] n);
    if (s == 0) wr(drive_status_pkg::IDX_PRESET_SEL, 32'(n) + 32'h1);
    else
    begin
      @(posedge clk);
      act_v[s-1] <= 1'b1;
      aidx <= n;
      @(posedge clk);
      act_v <= 3'h0;
    end
    @(posedge clk);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic tally_and_finish;
    $display("counts: checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // watchdog: the whole run needs a few hundred cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end

  initial
  begin
    void'($urandom(83761));
    settle(5);
    reset_n <= 1'b1;
    rchk(drive_status_pkg::IDX_STATUS, 32'h0);
    rchk(drive_status_pkg::IDX_CONFIG, drive_status_pkg::CONFIG_RESET);
    rdr(8'hFF); // unmapped index
    chk({30'h0, rs}, {30'h0, drive_status_pkg::RESP_SLVERR});
    wr(8'hFF, 32'h0); // unmapped write is refused
    chk({30'h0, bs}, {30'h0, drive_status_pkg::RESP_SLVERR});
    $display("test reset done");
    // random presets, every select mode and every source
    for (int k = 0; k < 8; k++)
    begin
      pv[k] = $urandom;
      wr(8'(drive_status_pkg::IDX_PRESET_BASE + 2 * k), pv[k]);
    end
    for (int m = 0; m < 4; m++)
    begin
      wr(drive_status_pkg::IDX_STATUS, 32'(m) << 9);
      for (int s = 0; s < 4; s++)
      begin
        i = 3'($urandom_range(7));
        c = $urandom;
        f = $urandom;
        cmd_p <= c;
        fnc_p <= f;
        // commanded offset wins when both selects are set
        exp_t = pv[i] + (m[0] ? c : (m == 2 ? f : 32'h0));
        fire(s, i);
        chk(tgt, exp_t);
      end
    end
    wr(drive_status_pkg::IDX_STATUS, 32'h0);
    $display("test presets done");
    wr(drive_status_pkg::IDX_IRQ_MASK, 32'h0000_7800);
    chk({30'h0, bs}, {30'h0, drive_status_pkg::RESP_OKAY});
    wr(drive_status_pkg::IDX_FILT_LO, 32'h0000_0055);
    chk(filt[0], 32'h0000_0055);
    oc <= 1'b1;
    settle(1);
    oc <= 1'b0;
    settle(2);
    chk(filt[0], drive_status_pkg::FILTER_DEFAULTS[0]);
    chk({31'h0, irq}, 32'h1);
    rchk(drive_status_pkg::IDX_STATUS, 32'h0000_0800);
    wr(drive_status_pkg::IDX_STATUS, 32'h0000_0800);
    chk({31'h0, irq}, 32'h0);
    $display("test overcurrent done");
    wr(drive_status_pkg::IDX_SUPPLY_MIN, 32'd100);
    sup <= 16'd99;
    rchk(drive_status_pkg::IDX_STATUS, 32'h0000_3000);
    sup <= 16'd120; // between minimum and 1.25 times it
    wr(drive_status_pkg::IDX_STATUS, 32'h0000_3000);
    rchk(drive_status_pkg::IDX_STATUS, 32'h0000_2000);
    wr(drive_status_pkg::IDX_CONFIG, 32'h0);
    sup <= 16'd50;
    wr(drive_status_pkg::IDX_STATUS, 32'h0000_3000);
    rchk(drive_status_pkg::IDX_STATUS, 32'h0000_2000);
    sup <= 16'd1000;
    wr(drive_status_pkg::IDX_STATUS, 32'h0000_3000);
    $display("test supply done");
    wr(drive_status_pkg::IDX_LIMIT_MIN, 32'd0);
    wr(drive_status_pkg::IDX_LIMIT_MAX, 32'd1000);
    act_p <= 32'd5000;
    settle(2);
    chk({31'h0, viol}, 32'h1);
    wr(drive_status_pkg::IDX_STATUS, 32'h0000_4000);
    chk({31'h0, enf}, 32'h0);
    chk({31'h0, viol}, 32'h0);
    rchk(drive_status_pkg::IDX_STATUS, 32'h0000_4000);
    act_p <= 32'd10;
    settle(3);
    chk({31'h0, enf}, 32'h1);
    rchk(drive_status_pkg::IDX_STATUS, 32'h0);
    act_p <= 32'd5000;
    zs <= 1'b1;
    settle(3);
    chk({31'h0, enf}, 32'h0);
    zs <= 1'b0;
    act_p <= 32'd10;
    settle(3);
    chk({31'h0, enf}, 32'h1);
    $display("test limits done");
    tally_and_finish();
  end
endmodule
